// [logic/gpx_expander.sv]
`timescale 1ns/1ps
`default_nettype none
module gpx_expander
    import gpx_pkg::*;
#(
    parameter logic [4:0] TGT_HI = TGT_HI_DEF
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out_out,
    output var  logic        sda_oe_out,
    input  wire logic        addr_strap_lo_in,
    input  wire logic        addr_strap_hi_in,
    input  wire logic [15:0] port_pins_in,
    output var  logic [15:0] port_pins_out,
    output var  logic [15:0] port_pins_oe_out,
    output var  logic        alert_n_out,
    output var  logic        alert_oe_out
);
    gpx_bank_if bus ();

    gpx_bank u_bank (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .bus     (bus.bank)
    );

    gpx_state_e  st_r, st_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic [7:0]  tx_r, tx_nxt;
    logic [2:0]  ptr_r, ptr_nxt;
    logic        sda_oe_r, sda_oe_nxt;
    logic        mack_r, mack_nxt;
    logic [15:0] snap_r, snap_nxt;
    logic        load_w;
    logic [7:0]  load_byte;
    logic        scl_q, sda_q, init_r;
    logic [1:0]  strap_r;
    logic [15:0] pin_out_r, pin_oe_r;
    logic        alert_r, alert_nxt;
    logic        rise_w, fall_w, start_w, stop_w;
    logic [15:0] live_v;
    logic [6:0]  own_addr;

    function automatic logic [7:0] half(input logic [15:0] v, input logic hi);
        half = hi ? v[15:8] : v[7:0];
    endfunction

    function automatic logic is_input_reg(input logic [2:0] a);
        is_input_reg = (a == REG_IN0) || (a == REG_IN1);
    endfunction

    // ==========================================================
    // Line events and live input levels.
    assign rise_w   = !scl_q && scl_in;
    assign fall_w   = scl_q && !scl_in;
    assign start_w  = scl_q && scl_in && sda_q && !sda_in;
    assign stop_w   = scl_q && scl_in && !sda_q && sda_in;
    assign live_v   = port_pins_in ^ bus.pol_q;
    assign own_addr = {TGT_HI, strap_r};
    assign bus.raddr = ptr_r;
    assign load_byte = is_input_reg(ptr_r) ? half(live_v, ptr_r[0]) : bus.rdata;

    // ==========================================================
    // Bus target machine.
    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        sh_nxt     = sh_r;
        tx_nxt     = tx_r;
        ptr_nxt    = ptr_r;
        sda_oe_nxt = sda_oe_r;
        mack_nxt   = mack_r;
        snap_nxt   = snap_r;
        load_w     = 1'b0;
        bus.we     = 1'b0;
        bus.waddr  = ptr_r;
        bus.wdata  = sh_r;
        if (!init_r) begin
            snap_nxt = live_v;
        end
        if (stop_w) begin
            st_nxt     = ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (start_w) begin
            st_nxt     = ST_ADDR;
            cnt_nxt    = CNT_ZERO;
            sda_oe_nxt = 1'b0;
        end else if (rise_w) begin
            case (st_r)
                ST_ADDR, ST_CMD, ST_WR: begin
                    sh_nxt  = {sh_r[6:0], sda_in};
                    cnt_nxt = cnt_r + CNT_ONE;
                end
                ST_RD:   cnt_nxt = cnt_r + CNT_ONE;
                ST_MACK: mack_nxt = !sda_in;
                default: ;
            endcase
        end else if (fall_w) begin
            case (st_r)
                ST_ADDR: begin
                    if (cnt_r == BYTE_BITS) begin
                        cnt_nxt = CNT_ZERO;
                        if (sh_r[7:1] == own_addr) begin
                            sda_oe_nxt = 1'b1;
                            st_nxt     = ST_AACK;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                ST_CMD: begin
                    if (cnt_r == BYTE_BITS) begin
                        cnt_nxt    = CNT_ZERO;
                        ptr_nxt    = sh_r[2:0];
                        sda_oe_nxt = 1'b1;
                        st_nxt     = ST_CACK;
                    end
                end
                ST_WR: begin
                    if (cnt_r == BYTE_BITS) begin
                        cnt_nxt    = CNT_ZERO;
                        bus.we     = !is_input_reg(ptr_r);
                        ptr_nxt    = {ptr_r[2:1], !ptr_r[0]};
                        sda_oe_nxt = 1'b1;
                        st_nxt     = ST_CACK;
                    end
                end
                ST_AACK: begin
                    if (sh_r[0]) begin
                        load_w = 1'b1;
                    end else begin
                        sda_oe_nxt = 1'b0;
                        st_nxt     = ST_CMD;
                    end
                end
                ST_CACK: begin
                    sda_oe_nxt = 1'b0;
                    st_nxt     = ST_WR;
                end
                ST_RD: begin
                    if (cnt_r == BYTE_BITS) begin
                        cnt_nxt    = CNT_ZERO;
                        sda_oe_nxt = 1'b0;
                        st_nxt     = ST_MACK;
                    end else begin
                        tx_nxt     = {tx_r[6:0], 1'b0};
                        sda_oe_nxt = !tx_r[6];
                    end
                end
                ST_MACK: begin
                    if (mack_r) begin
                        load_w = 1'b1;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
        if (load_w) begin
            tx_nxt     = load_byte;
            sda_oe_nxt = !load_byte[7];
            cnt_nxt    = CNT_ZERO;
            ptr_nxt    = {ptr_r[2:1], !ptr_r[0]};
            st_nxt     = ST_RD;
            if (is_input_reg(ptr_r)) begin
                snap_nxt[{ptr_r[0], 3'h0} +: 8] = load_byte;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r     <= ST_IDLE;
            cnt_r    <= CNT_ZERO;
            sh_r     <= 8'h00;
            tx_r     <= 8'h00;
            ptr_r    <= REG_IN0;
            sda_oe_r <= 1'b0;
            mack_r   <= 1'b0;
            snap_r   <= 16'h0000;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            sh_r     <= sh_nxt;
            tx_r     <= tx_nxt;
            ptr_r    <= ptr_nxt;
            sda_oe_r <= sda_oe_nxt;
            mack_r   <= mack_nxt;
            snap_r   <= snap_nxt;
        end
    end

    // ==========================================================
    // Pin drivers, alert and line sampling.
    always_comb begin
        alert_nxt = init_r && (live_v != snap_r);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            init_r    <= 1'b0;
            strap_r   <= 2'h0;
            pin_out_r <= {OUT_RST, OUT_RST};
            pin_oe_r  <= 16'h0000;
            alert_r   <= 1'b0;
        end else begin
            scl_q     <= scl_in;
            sda_q     <= sda_in;
            init_r    <= 1'b1;
            strap_r   <= {addr_strap_hi_in, addr_strap_lo_in};
            pin_out_r <= bus.out_q;
            pin_oe_r  <= ~bus.dir_q;
            alert_r   <= alert_nxt;
        end
    end

    assign sda_out_out      = 1'b0;
    assign sda_oe_out       = sda_oe_r;
    assign port_pins_out    = pin_out_r;
    assign port_pins_oe_out = pin_oe_r;
    assign alert_n_out      = 1'b0;
    assign alert_oe_out     = alert_r;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    property p_alert_set;
        (init_r && live_v != snap_r) |=> alert_oe_out;
    endproperty
    a_alert_set: assert property (p_alert_set)
        else $error("Alert not asserted on input change.");

    property p_alert_cause;
        alert_oe_out |-> $past(live_v != snap_r) && alert_n_out == 1'b0;
    endproperty
    a_alert_cause: assert property (p_alert_cause)
        else $error("Alert asserted without an input change.");

    property p_reset_state;
        $rose(rstn_in) |-> st_r == ST_IDLE && port_pins_oe_out == 16'h0000;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("State not at defaults after reset.");

    property p_out_hold;
        $changed(port_pins_out) |-> $past(bus.we, 2);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("Output pins changed without a write.");

    property p_no_input_write;
        bus.we |-> !is_input_reg(bus.waddr);
    endproperty
    a_no_input_write: assert property (p_no_input_write)
        else $error("Write reached an input register.");

    property p_addr_match;
        (st_r == ST_ADDR && st_nxt == ST_AACK) |-> sh_r[7:1] == {TGT_HI, strap_r};
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("Address acknowledged without a match.");

    property p_inv_report;
        (load_w && is_input_reg(ptr_r)) |=>
            tx_r == $past(half(port_pins_in ^ bus.pol_q, ptr_r[0]));
    endproperty
    a_inv_report: assert property (p_inv_report)
        else $error("Input byte not inverted per polarity.");

    property p_read_clears;
        (load_w && is_input_reg(ptr_r)) |=>
            half(snap_r, $past(ptr_r[0])) == $past(load_byte);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("Input read did not refresh stored value.");

    property p_sda_when_low;
        $changed(sda_oe_out) |-> !$past(scl_in) || $past(start_w || stop_w);
    endproperty
    a_sda_when_low: assert property (p_sda_when_low)
        else $error("Data line changed while clock high.");
endmodule // gpx_expander
`default_nettype wire

// [logic/gpx_pkg.sv]
`default_nettype none
package gpx_pkg;
    // ==========================================================
    // Widths and register selectors.
    localparam int         PORT_W   = 8;
    localparam int         PINS_W   = 16;
    localparam logic [2:0] REG_IN0  = 3'h0;
    localparam logic [2:0] REG_IN1  = 3'h1;
    localparam logic [2:0] REG_OUT0 = 3'h2;
    localparam logic [2:0] REG_OUT1 = 3'h3;
    localparam logic [2:0] REG_POL0 = 3'h4;
    localparam logic [2:0] REG_POL1 = 3'h5;
    localparam logic [2:0] REG_DIR0 = 3'h6;
    localparam logic [2:0] REG_DIR1 = 3'h7;
    // ==========================================================
    // Reset values.
    localparam logic [7:0] OUT_RST  = 8'hFF;
    localparam logic [7:0] POL_RST  = 8'h00;
    localparam logic [7:0] DIR_RST  = 8'hFF;
    // Upper five target address bits; the value is arbitrary.
    localparam logic [4:0] TGT_HI_DEF = 5'h10;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [3:0] CNT_ZERO   = 4'h0;
    localparam logic [3:0] CNT_ONE    = 4'h1;
    // ==========================================================
    // Bus target states.
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_AACK = 8'h04,
        ST_CMD  = 8'h08,
        ST_CACK = 8'h10,
        ST_WR   = 8'h20,
        ST_RD   = 8'h40,
        ST_MACK = 8'h80
    } gpx_state_e;
endpackage
`default_nettype wire

// [logic/gpx_bank_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface gpx_bank_if;
    logic        we;
    logic [2:0]  waddr;
    logic [7:0]  wdata;
    logic [2:0]  raddr;
    logic [7:0]  rdata;
    logic [15:0] out_q;
    logic [15:0] pol_q;
    logic [15:0] dir_q;
    modport ctrl (output we, waddr, wdata, raddr, input rdata, out_q, pol_q, dir_q);
    modport bank (input we, waddr, wdata, raddr, output rdata, out_q, pol_q, dir_q);
endinterface
`default_nettype wire

// [logic/gpx_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module gpx_bank
    import gpx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    gpx_bank_if.bank bus
);
    logic [15:0] out_r, out_nxt;
    logic [15:0] pol_r, pol_nxt;
    logic [15:0] dir_r, dir_nxt;
    logic [7:0]  rdata_r, rdata_nxt;

    function automatic logic [7:0] half(input logic [15:0] v, input logic hi);
        half = hi ? v[15:8] : v[7:0];
    endfunction

    // ==========================================================
    // Writable pairs and registered read port.
    always_comb begin
        out_nxt = out_r;
        pol_nxt = pol_r;
        dir_nxt = dir_r;
        if (bus.we) begin
            case (bus.waddr)
                REG_OUT0: out_nxt[7:0]  = bus.wdata;
                REG_OUT1: out_nxt[15:8] = bus.wdata;
                REG_POL0: pol_nxt[7:0]  = bus.wdata;
                REG_POL1: pol_nxt[15:8] = bus.wdata;
                REG_DIR0: dir_nxt[7:0]  = bus.wdata;
                REG_DIR1: dir_nxt[15:8] = bus.wdata;
                default: ;
            endcase
        end
        case (bus.raddr[2:1])
            REG_OUT0[2:1]: rdata_nxt = half(out_r, bus.raddr[0]);
            REG_POL0[2:1]: rdata_nxt = half(pol_r, bus.raddr[0]);
            REG_DIR0[2:1]: rdata_nxt = half(dir_r, bus.raddr[0]);
            default:       rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_r   <= {OUT_RST, OUT_RST};
            pol_r   <= {POL_RST, POL_RST};
            dir_r   <= {DIR_RST, DIR_RST};
            rdata_r <= 8'h00;
        end else begin
            out_r   <= out_nxt;
            pol_r   <= pol_nxt;
            dir_r   <= dir_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign bus.out_q = out_r;
    assign bus.pol_q = pol_r;
    assign bus.dir_q = dir_r;
    assign bus.rdata = rdata_r;

    property p_out_readback;
        @(posedge clk_in) disable iff (!rstn_in)
        (bus.raddr == REG_OUT1) |=> (bus.rdata == $past(out_r[15:8]));
    endproperty
    a_out_readback: assert property (p_out_readback)
        else $error("Output register read does not return the stored value.");
endmodule // gpx_bank
`default_nettype wire

// [tb/gpx_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bus master on the far side of the link.
module gpx_host_model #(
    parameter int HALF = 25
) (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic sda_oe_out
);
    // One clock phase is HALF cycles, so a full bit stays at 400 kHz.
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // Data moves only in the middle of the low phase, never near an edge of the clock line.
    task automatic bit_cycle(input logic drive_low, output logic seen);
        wait_clk(HALF / 2);
        sda_oe_out = drive_low;
        wait_clk(HALF - HALF / 2);
        scl_out = 1'b1;
        wait_clk(HALF / 2);
        seen = sda_in;
        wait_clk(HALF - HALF / 2);
        scl_out = 1'b0;
    endtask

    task automatic start_cond();
        wait_clk(HALF / 2);
        sda_oe_out = 1'b0;
        wait_clk(HALF / 2);
        scl_out = 1'b1;
        wait_clk(HALF);
        sda_oe_out = 1'b1;
        wait_clk(HALF);
        scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(HALF / 2);
        sda_oe_out = 1'b1;
        wait_clk(HALF / 2);
        scl_out = 1'b1;
        wait_clk(HALF);
        sda_oe_out = 1'b0;
        wait_clk(HALF);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(~d[i], s);
        end
        bit_cycle(1'b0, ack_n);
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b0, s);
            d[i] = s;
        end
        bit_cycle(~last, s);
    endtask
endmodule // gpx_host_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gpx_pkg::*;
    // ==========================================================
    // Wiring.
    logic        clk = 1'b0;
    logic        rstn;
    logic        strap_lo;
    logic        strap_hi;
    logic [15:0] ext_pins;
    logic [15:0] rd;
    logic        a0;
    logic        a1;
    int          errors;
    int          check_count;
    wire logic        scl;
    wire logic        host_oe;
    wire logic        dut_sda_out;
    wire logic        dut_sda_oe;
    wire logic        sda_wire;
    wire logic [15:0] pins_in;
    wire logic [15:0] pins_out;
    wire logic [15:0] pins_oe;
    wire logic        alert_lvl;
    wire logic        alert_oe;
    wire logic        alert_wire;

    // Pull-ups on the data and alert lines; driven pins show the output latch.
    assign sda_wire   = (dut_sda_oe ? dut_sda_out : 1'b1) & ~host_oe;
    assign alert_wire = alert_oe ? alert_lvl : 1'b1;
    assign pins_in    = (pins_oe & pins_out) | (~pins_oe & ext_pins);

    always #25 clk = ~clk;

    gpx_expander #(.TGT_HI(TGT_HI_DEF)) i_dut (
        .clk_in           (clk),
        .rstn_in          (rstn),
        .scl_in           (scl),
        .sda_in           (sda_wire),
        .sda_out_out      (dut_sda_out),
        .sda_oe_out       (dut_sda_oe),
        .addr_strap_lo_in (strap_lo),
        .addr_strap_hi_in (strap_hi),
        .port_pins_in     (pins_in),
        .port_pins_out    (pins_out),
        .port_pins_oe_out (pins_oe),
        .alert_n_out      (alert_lvl),
        .alert_oe_out     (alert_oe)
    );

    gpx_host_model i_host (
        .clk_in     (clk),
        .sda_in     (sda_wire),
        .scl_out    (scl),
        .sda_oe_out (host_oe)
    );

    // ==========================================================
    // Tasks.
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [2:0] sel, input logic [7:0] d);
        logic k0, k1, k2;
        i_host.start_cond();
        i_host.wr_byte({TGT_HI_DEF, strap_hi, strap_lo, 1'b0}, k0);
        i_host.wr_byte({5'h00, sel}, k1);
        i_host.wr_byte(d, k2);
        i_host.stop_cond();
        chk("write acks", {13'h0000, k0, k1, k2}, 16'h0000);
    endtask

    // Reads two bytes: the selected register, then its pair partner.
    task automatic reg_rd(input logic [2:0] sel, output logic [15:0] d);
        logic k0, k1, k2;
        i_host.start_cond();
        i_host.wr_byte({TGT_HI_DEF, strap_hi, strap_lo, 1'b0}, k0);
        i_host.wr_byte({5'h00, sel}, k1);
        i_host.start_cond();
        i_host.wr_byte({TGT_HI_DEF, strap_hi, strap_lo, 1'b1}, k2);
        i_host.rd_byte(1'b0, d[7:0]);
        i_host.rd_byte(1'b1, d[15:8]);
        i_host.stop_cond();
        chk("read acks", {13'h0000, k0, k1, k2}, 16'h0000);
    endtask

    task automatic wait_alert(input logic exp);
        int n;
        n = 0;
        while (alert_oe !== exp && n < 20) begin
            @(negedge clk);
            n++;
        end
        // A wait that runs out counts as a mismatch and ends the run.
        if (alert_oe !== exp) begin
            chk("alert wait", {15'h0000, alert_oe}, {15'h0000, exp});
            tally_and_finish();
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Sequence.
    initial begin
        rstn        = 1'b0;
        strap_lo    = 1'b0;
        strap_hi    = 1'b0;
        ext_pins    = 16'hA55A;
        errors      = 0;
        check_count = 0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk("pins oe", pins_oe, 16'h0000);
        chk("pins out", pins_out, 16'hFFFF);
        chk("alert", {15'h0000, alert_wire}, 16'h0001);
        reg_rd(REG_IN0, rd);
        chk("input", rd, 16'hA55A);
        reg_rd(REG_OUT0, rd);
        chk("output", rd, {OUT_RST, OUT_RST});
        reg_rd(REG_POL0, rd);
        chk("inversion", rd, {POL_RST, POL_RST});
        reg_rd(REG_DIR0, rd);
        chk("direction", rd, {DIR_RST, DIR_RST});
        for (int s = 0; s < 4; s++) begin
            strap_lo = s[0];
            strap_hi = s[1];
            @(negedge clk);
            i_host.start_cond();
            i_host.wr_byte({TGT_HI_DEF, s[1], ~s[0], 1'b0}, a0);
            i_host.start_cond();
            i_host.wr_byte({TGT_HI_DEF, s[1], s[0], 1'b0}, a1);
            i_host.stop_cond();
            chk("strap acks", {14'h0000, a0, a1}, 16'h0002);
        end
        reg_wr(REG_OUT0, 8'h3C);
        reg_wr(REG_OUT1, 8'hC3);
        reg_wr(REG_DIR0, 8'h00);
        chk("pins oe", pins_oe, 16'h00FF);
        chk("pins out", pins_out, 16'hC33C);
        reg_rd(REG_OUT1, rd);
        chk("output", rd, 16'h3CC3);
        reg_rd(REG_IN0, rd);
        chk("input", rd, 16'hA53C);
        reg_wr(REG_IN1, 8'h00);
        reg_rd(REG_IN1, rd);
        chk("input", rd, 16'h3CA5);
        reg_wr(REG_POL1, 8'hFF);
        reg_rd(REG_IN0, rd);
        chk("inverted input", rd, 16'h5A3C);
        wait_alert(1'b0);
        chk("alert", {15'h0000, alert_wire}, 16'h0001);
        ext_pins = 16'hA75A;
        wait_alert(1'b1);
        chk("alert", {15'h0000, alert_wire}, 16'h0000);
        ext_pins = 16'hA55A;
        wait_alert(1'b0);
        chk("alert", {15'h0000, alert_wire}, 16'h0001);
        ext_pins = 16'hA75A;
        wait_alert(1'b1);
        chk("alert", {15'h0000, alert_wire}, 16'h0000);
        reg_rd(REG_IN1, rd);
        chk("inverted input", rd, 16'h3C58);
        wait_alert(1'b0);
        chk("alert", {15'h0000, alert_wire}, 16'h0001);
        reg_wr(REG_DIR1, 8'hFF);
        reg_rd(REG_DIR0, rd);
        chk("direction", rd, 16'hFF00);
        reg_rd(REG_POL0, rd);
        chk("inversion", rd, 16'hFF00);
        chk("sda idle", {15'h0000, dut_sda_oe}, 16'h0000);
        chk("pins out", pins_out, 16'hC33C);
        rstn = 1'b0;
        @(negedge clk);
        chk("pins oe", pins_oe, 16'h0000);
        chk("pins out", pins_out, 16'hFFFF);
        chk("alert", {15'h0000, alert_wire}, 16'h0001);
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        reg_rd(REG_OUT0, rd);
        chk("output", rd, {OUT_RST, OUT_RST});
        reg_rd(REG_POL0, rd);
        chk("inversion", rd, {POL_RST, POL_RST});
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
